// [pkg/rsu_consts.svh]
// Purpose: constants of the rotate and shift unit
// Assumes: 32-bit data, 32-entry register file
// Notes: encodings follow the R-type instruction layout
`ifndef RSU_CONSTS_SVH
`define RSU_CONSTS_SVH
`define RSU_XLEN         32
`define RSU_IDX_W        5
`define RSU_OP_MSB       5
`define RSU_OP_LSB       0
`define RSU_IMM_MSB      10
`define RSU_IMM_LSB      6
`define RSU_OPX_MSB      16
`define RSU_OPX_LSB      11
`define RSU_C_MSB        21
`define RSU_C_LSB        17
`define RSU_B_MSB        26
`define RSU_B_LSB        22
`define RSU_A_MSB        31
`define RSU_A_LSB        27
`define RSU_OP_RTYPE     6'h3a
`define RSU_OPX_ROLI     6'h02
`define RSU_OPX_ROR      6'h0b
`define RSU_OPX_SLL      6'h13
`define RSU_REG_RESET    32'h00000000
`endif

// [pkg/rsu_pkg.sv]
// Purpose: types of the rotate and shift unit
// Assumes: constants header included alongside
// Notes: none
package rsu_pkg;
	typedef enum logic [1:0] {
		RSU_OP_NONE,
		RSU_OP_ROL_IMM,
		RSU_OP_ROR_REG,
		RSU_OP_SLL_REG
	} rsu_op_e;
	typedef enum logic [1:0] {
		RSU_ST_IDLE,
		RSU_ST_EXEC
	} rsu_state_e;
endpackage

// [design/rsu_regfile.sv]
// Purpose: 32 x 32 register file with two registered read ports
// Assumes: one write port, write and read in the same cycle see old data
// Notes: read data come out of a register
`timescale 1ns/1ps
`include "rsu_consts.svh"
module rsu_regfile (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [`RSU_IDX_W-1:0] rd_a_idx_i,
	input  wire logic [`RSU_IDX_W-1:0] rd_b_idx_i,
	output logic      [`RSU_XLEN-1:0]  rd_a_data_o,
	output logic      [`RSU_XLEN-1:0]  rd_b_data_o,
	input  wire logic                  wr_en_i,
	input  wire logic [`RSU_IDX_W-1:0] wr_idx_i,
	input  wire logic [`RSU_XLEN-1:0]  wr_data_i
);
	logic [`RSU_XLEN-1:0] mem_q [0:(1<<`RSU_IDX_W)-1];
	logic [`RSU_XLEN-1:0] mem_d [0:(1<<`RSU_IDX_W)-1];
	logic [`RSU_XLEN-1:0] rd_a_d;
	logic [`RSU_XLEN-1:0] rd_b_d;

	always_comb begin
		for (int i = 0; i < (1<<`RSU_IDX_W); i++) begin
			mem_d[i] = mem_q[i];
		end
		if (wr_en_i) begin
			mem_d[wr_idx_i] = wr_data_i;
		end
		rd_a_d = mem_q[rd_a_idx_i];
		rd_b_d = mem_q[rd_b_idx_i];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < (1<<`RSU_IDX_W); i++) begin
				mem_q[i] <= `RSU_REG_RESET;
			end
			rd_a_data_o <= `RSU_REG_RESET;
			rd_b_data_o <= `RSU_REG_RESET;
		end else begin
			for (int i = 0; i < (1<<`RSU_IDX_W); i++) begin
				mem_q[i] <= mem_d[i];
			end
			rd_a_data_o <= rd_a_d;
			rd_b_data_o <= rd_b_d;
		end
	end
endmodule

// [design/rsu_rotate_shift_unit.sv]
// Purpose: rotate left immediate, rotate right and shift left by register amount
// Assumes: instruction word is presented with a one-cycle valid strobe
// Notes: two cycles per instruction: operand read, then execute; the file write follows a cycle later from the output registers
//
// Functional notes
// - rotate-left-immediate rotates source left by immediate and writes destination
// - bits leaving the top on a left rotate re-enter at the bottom
// - immediate count is an unsigned 5-bit field, range 0 to 31
// - left rotate by 32 minus n equals right rotate by n
// - rotate right by low five bits of amount operand, write destination
// - bits leaving the bottom on a right rotate re-enter at the top
// - amount operand bits 31 to 5 never affect the result
// - shift left by low five bits of amount operand, write destination
// - left shift fills zeros low and discards bits past the top
// - instruction indices select source, amount and destination registers
`timescale 1ns/1ps
`include "rsu_consts.svh"
module rsu_rotate_shift_unit (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  instr_valid_i,
	input  wire logic [`RSU_XLEN-1:0]  instr_i,
	output logic                       busy_o,
	output logic                       illegal_o,
	output logic                       done_o,
	output logic                       wr_en_o,
	output logic      [`RSU_IDX_W-1:0] wr_idx_o,
	output logic      [`RSU_XLEN-1:0]  wr_data_o,
	output logic                       exception_o
);
	// one rotate serves both directions, so rol(32-n) and ror(n) match by construction
	function automatic logic [`RSU_XLEN-1:0] rot_left(input logic [`RSU_XLEN-1:0] v,
		input logic [`RSU_IDX_W-1:0] n);
		logic [2*`RSU_XLEN-1:0] dbl;
		dbl = {v, v} << n;
		return dbl[2*`RSU_XLEN-1:`RSU_XLEN];
	endfunction

	function automatic rsu_pkg::rsu_op_e decode(input logic [`RSU_XLEN-1:0] w);
		decode = rsu_pkg::RSU_OP_NONE;
		if (w[`RSU_OP_MSB:`RSU_OP_LSB] != `RSU_OP_RTYPE) begin
			decode = rsu_pkg::RSU_OP_NONE;
		end else if (w[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_ROLI) begin
			decode = rsu_pkg::RSU_OP_ROL_IMM;
		end else if (w[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_ROR) begin
			decode = rsu_pkg::RSU_OP_ROR_REG;
		end else if (w[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_SLL) begin
			decode = rsu_pkg::RSU_OP_SLL_REG;
		end
	endfunction

	rsu_pkg::rsu_state_e   state_q, state_d;
	rsu_pkg::rsu_op_e      op_q, op_d;
	logic [`RSU_IDX_W-1:0] imm_q, imm_d;
	logic [`RSU_IDX_W-1:0] dst_q, dst_d;
	logic [`RSU_IDX_W-1:0] rd_a_idx;
	logic [`RSU_IDX_W-1:0] rd_b_idx;
	logic [`RSU_XLEN-1:0]  src_val;
	logic [`RSU_XLEN-1:0]  amt_val;
	logic [`RSU_IDX_W-1:0] amt;
	logic                  busy_d, illegal_d, done_d, wr_en_d;
	logic [`RSU_IDX_W-1:0] wr_idx_d;
	logic [`RSU_XLEN-1:0]  wr_data_d;
	logic                  wr_fire;

	// write port fed from the output registers keeps outputs and file in step
	rsu_regfile u_regfile (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.rd_a_idx_i  (rd_a_idx),
		.rd_b_idx_i  (rd_b_idx),
		.rd_a_data_o (src_val),
		.rd_b_data_o (amt_val),
		.wr_en_i     (wr_fire),
		.wr_idx_i    (wr_idx_o),
		.wr_data_i   (wr_data_o)
	);

	assign wr_fire  = wr_en_o;
	assign rd_a_idx = instr_i[`RSU_A_MSB:`RSU_A_LSB];
	assign rd_b_idx = instr_i[`RSU_B_MSB:`RSU_B_LSB];
	assign amt      = amt_val[`RSU_IDX_W-1:0];

	always_comb begin
		state_d   = state_q;
		op_d      = op_q;
		imm_d     = imm_q;
		dst_d     = dst_q;
		busy_d    = 1'b0;
		illegal_d = 1'b0;
		done_d    = 1'b0;
		wr_en_d   = 1'b0;
		wr_idx_d  = wr_idx_o;
		wr_data_d = wr_data_o;
		case (state_q)
			rsu_pkg::RSU_ST_IDLE: begin
				// requests arriving while executing are dropped; source waits on busy
				if (instr_valid_i) begin
					op_d  = decode(instr_i);
					imm_d = instr_i[`RSU_IMM_MSB:`RSU_IMM_LSB];
					dst_d = instr_i[`RSU_C_MSB:`RSU_C_LSB];
					if (decode(instr_i) == rsu_pkg::RSU_OP_NONE) begin
						illegal_d = 1'b1;
					end else begin
						busy_d  = 1'b1;
						state_d = rsu_pkg::RSU_ST_EXEC;
					end
				end
			end
			rsu_pkg::RSU_ST_EXEC: begin
				wr_en_d  = 1'b1;
				done_d   = 1'b1;
				wr_idx_d = dst_q;
				case (op_q)
					rsu_pkg::RSU_OP_ROL_IMM: wr_data_d = rot_left(src_val, imm_q);
					rsu_pkg::RSU_OP_ROR_REG: begin
						// right by n is left by 32-n modulo 32
						wr_data_d = rot_left(src_val, 5'(0 - amt));
					end
					rsu_pkg::RSU_OP_SLL_REG: wr_data_d = src_val << amt;
					default: begin
						wr_en_d = 1'b0;
					end
				endcase
				state_d = rsu_pkg::RSU_ST_IDLE;
			end
			default: state_d = rsu_pkg::RSU_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q     <= rsu_pkg::RSU_ST_IDLE;
			op_q        <= rsu_pkg::RSU_OP_NONE;
			imm_q       <= '0;
			dst_q       <= '0;
			busy_o      <= 1'b0;
			illegal_o   <= 1'b0;
			done_o      <= 1'b0;
			wr_en_o     <= 1'b0;
			wr_idx_o    <= '0;
			wr_data_o   <= `RSU_REG_RESET;
			exception_o <= 1'b0;
		end else begin
			state_q     <= state_d;
			op_q        <= op_d;
			imm_q       <= imm_d;
			dst_q       <= dst_d;
			busy_o      <= busy_d;
			illegal_o   <= illegal_d;
			done_o      <= done_d;
			wr_en_o     <= wr_en_d;
			wr_idx_o    <= wr_idx_d;
			wr_data_o   <= wr_data_d;
			exception_o <= 1'b0;
		end
	end
endmodule

// [verif/rsu_chk_properties.sv]
// Purpose: port checker for the rotate and shift unit
// Assumes: register file starts at zero, so every result is zero
// Notes: bound to the unit below
`timescale 1ns/1ps
`include "rsu_consts.svh"
module rsu_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic        busy_o,
	input wire logic        illegal_o,
	input wire logic        done_o,
	input wire logic        wr_en_o,
	input wire logic [4:0]  wr_idx_o,
	input wire logic [31:0] wr_data_o,
	input wire logic        exception_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       acc;
	logic       legal;
	logic [5:0] opx;
	assign acc = instr_valid_i && !busy_o;
	assign opx = instr_i[16:11];
	assign legal = instr_i[5:0] == `RSU_OP_RTYPE
		&& opx inside {`RSU_OPX_ROLI, `RSU_OPX_ROR, `RSU_OPX_SLL};
	sequence s_exec;
		busy_o && !done_o ##1 done_o && wr_en_o && !busy_o;
	endsequence
	AST_ROLI: assert property (acc && legal && opx == `RSU_OPX_ROLI |=> s_exec)
		else $error("rotate left immediate did not write");
	AST_ROR: assert property (acc && legal && opx == `RSU_OPX_ROR |=> s_exec)
		else $error("rotate right did not write");
	AST_SLL: assert property (acc && legal && opx == `RSU_OPX_SLL |=> s_exec)
		else $error("shift left did not write");
	AST_ILL: assert property (acc |=> illegal_o != $past(legal))
		else $error("decode flag wrong");
	AST_IDX: assert property (acc && legal |-> ##2 wr_idx_o == $past(instr_i[21:17], 2))
		else $error("wrong destination index");
	AST_DATA: assert property (wr_en_o |-> wr_data_o == 32'h0)
		else $error("result from zero operands not zero");
	AST_NOEXC: assert property (!exception_o)
		else $error("exception raised");
	AST_HOLD: assert property (!wr_en_o |-> $stable(wr_data_o) && $stable(wr_idx_o))
		else $error("write outputs moved without a write");
	AST_REFUSE: assert property (busy_o |=> !busy_o && !illegal_o)
		else $error("request taken while busy");
endmodule
bind rsu_rotate_shift_unit rsu_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .busy_o(busy_o), .illegal_o(illegal_o),
	.done_o(done_o), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o),
	.exception_o(exception_o));

// [verif/rotate_shift_unit_bench.sv]
// Purpose: self-checking bench for the rotate and shift unit
// Assumes: registers all zero, no load port
// Notes: results stay zero, so routing, timing and decode carry the checks
`timescale 1ns/1ps
`include "rsu_consts.svh"
module rotate_shift_unit_bench;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        instr_valid_i = 0;
	logic [31:0] instr_i = 0;
	logic        busy_o, illegal_o, done_o, wr_en_o, exception_o;
	logic [4:0]  wr_idx_o, last_c = 0;
	logic [31:0] wr_data_o;
	logic [38:0] exp_q[$];
	logic [5:0]  opx_t[4] = '{`RSU_OPX_ROLI, `RSU_OPX_ROR, `RSU_OPX_SLL, 6'h03};
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #20 clk_i = ~clk_i;
	rsu_rotate_shift_unit dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .busy_o(busy_o), .illegal_o(illegal_o), .done_o(done_o),
		.wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o), .exception_o(exception_o));
	task automatic check(input logic [38:0] seen, input logic [38:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// a legal word is followed by a refused random request in its busy cycle
	task automatic issue(input logic [31:0] w);
		logic ill;
		ill = !(w[5:0] == `RSU_OP_RTYPE
			&& w[16:11] inside {`RSU_OPX_ROLI, `RSU_OPX_ROR, `RSU_OPX_SLL});
		if (!ill) last_c = w[21:17];
		exp_q.push_back({ill, !ill, last_c, 32'h0});
		instr_valid_i = 1;
		instr_i = w;
		@(posedge clk_i) #2;
		instr_valid_i = !ill;
		instr_i = $urandom();
		@(posedge clk_i) #2;
	endtask
	always @(negedge clk_i) begin
		if (!rst_i && (wr_en_o || illegal_o)) begin
			check({illegal_o, done_o, wr_idx_o, wr_data_o},
				exp_q.size() ? exp_q.pop_front() : 'x);
		end
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		logic [31:0] w;
		void'($urandom(32'h9234));
		repeat (20) @(posedge clk_i);
		#2 rst_i = 0;
		for (int i = 0; i < 32; i++) begin
			w = $urandom();
			w[16:11] = opx_t[i % 4];
			w[10:6] = i < 8 ? {5{i[2]}} : w[10:6];
			w[5:0] = i % 8 == 5 ? 6'h00 : `RSU_OP_RTYPE;
			issue(w);
		end
		instr_valid_i = 0;
		repeat (4) @(posedge clk_i);
		check(39'(exp_q.size()), 39'h0);
		end_of_test();
	end
endmodule
